//--- hw/adcctl_pkg.sv
/*
 Constants for the converter control block: register offsets, field positions,
 reset values, clock select codes and timing figures.
 Assumes a Wishbone slave with 8-bit data in the low bits of a 32-bit word.
*/
package adcctl_pkg;
	// ----------------------------------------------------------------
	// Register map.
	// ----------------------------------------------------------------
	// Printed offsets are not multiples of four, so they are indices.
	localparam logic [7:0] CONVERTER_CONTROL_IDX = 8'h1F;
	localparam logic [7:0] ANALOG_PIN_AND_CLOCK_SELECT_IDX = 8'h9F;
	localparam logic [9:0] CONVERTER_CONTROL_ADDR = {CONVERTER_CONTROL_IDX, 2'h0};
	localparam logic [9:0] ANALOG_PIN_AND_CLOCK_SELECT_ADDR =
		{ANALOG_PIN_AND_CLOCK_SELECT_IDX, 2'h0};

	// ----------------------------------------------------------------
	// Control register fields.
	// ----------------------------------------------------------------
	localparam int RESULT_JUSTIFY_BIT = 7;
	localparam int REFERENCE_SOURCE_SELECT_BIT = 6;
	localparam int CHANNEL_SELECT_LSB = 2;
	localparam int CONVERSION_STATUS_BIT = 1;
	localparam int CONVERTER_POWER_ON_BIT = 0;
	localparam logic [7:0] CONVERTER_CONTROL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Analog select register fields.
	// ----------------------------------------------------------------
	localparam int CLOCK_SELECT_LSB = 4;
	localparam logic [2:0] CLOCK_SELECT_RESET = 3'h0;
	localparam logic [3:0] PIN_ANALOG_SELECT_RESET = 4'hF;

	// ----------------------------------------------------------------
	// Conversion clock select codes.
	// ----------------------------------------------------------------
	localparam logic [2:0] CLK_DIV2 = 3'h0;
	localparam logic [2:0] CLK_DIV8 = 3'h1;
	localparam logic [2:0] CLK_DIV32 = 3'h2;
	localparam logic [2:0] CLK_DIV4 = 3'h4;
	localparam logic [2:0] CLK_DIV16 = 3'h5;
	localparam logic [2:0] CLK_DIV64 = 3'h6;
	localparam logic [1:0] CLK_RC_LOW_BITS = 2'h3;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int SYS_CLOCK_HZ = 20000000;
	localparam int RC_CLOCK_MAX_KHZ = 500;
	// Least period of the internal RC clock, rounded up to system cycles.
	localparam int RC_CLOCK_CYCLES =
		(SYS_CLOCK_HZ + RC_CLOCK_MAX_KHZ * 1000 - 1) / (RC_CLOCK_MAX_KHZ * 1000);
	localparam int DIV_WIDTH = 7;
	localparam int CONV_BITS = 10;
	localparam int RESULT_WIDTH = 10;
endpackage

//--- hw/adcctl_top.sv
/*
 Converter control block: control and analog select registers on a classic
 Wishbone slave, conversion clock divider, conversion sequencer and result
 justification.
 Assumes the analog core takes one sample per bit period when enabled and
 returns a bit decision on CORE_BIT; inputs are synchronous to CLK_SYS.
*/
// Notes on behaviour
// - Result sits right-justified in the 16-bit pair when the format bit is 1, else left.
// - Reference comes from the external pin when its select bit is 1, else from supply.
// - The 3-bit channel field routes inputs zero to three for codes 000 to 011.
// - The status bit reads as completed or idle whenever no conversion runs.
// - With the enable bit at 1 the converter runs; at 0 it is shut off and draws nothing.
// - The unused control register bit reads zero and ignores writes.
// - Clock select codes 000,001,010,100,101,110 divide the system clock by 2,8,32,4,16,64.
// - Clock select codes with low bits 11 use the internal RC clock of at most 500 kHz.
// - The top bit of the analog select register reads zero.
// - Software sets the status bit to start; hardware clears it on completion.
// - Each analog select bit at 1 makes its pin analog and cuts its digital input.
`timescale 1ns/1ps
module adcctl_top #(
	parameter int CONV_BITS = adcctl_pkg::CONV_BITS
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [9:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic CORE_BIT,
	output logic CORE_POWER_ON,
	output logic CORE_SAMPLE,
	output logic CORE_REF_EXTERNAL,
	output logic [1:0] CORE_CHANNEL,
	output logic CORE_CHANNEL_VALID,
	output logic [3:0] PIN_ANALOG,
	output logic [3:0] PIN_DIGITAL_IN_EN,
	output logic [15:0] RESULT_PAIR,
	output logic CONVERSION_DONE
);
	// ----------------------------------------------------------------
	// Parameter check.
	// ----------------------------------------------------------------
	if (CONV_BITS < 1 || CONV_BITS > adcctl_pkg::RESULT_WIDTH) begin : g_bad_bits
		$error("CONV_BITS must lie between 1 and the result width");
	end

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ADCCTL_IDLE = 3'h1,
		ADCCTL_CONVERT = 3'h2,
		ADCCTL_FINISH = 3'h4
	} adcctl_state_t;

	typedef struct packed {
		adcctl_state_t state;
		logic result_justify;
		logic reference_source_select;
		logic [2:0] input_channel_select;
		logic conversion_status;
		logic converter_power_on;
		logic [2:0] conversion_clock_select;
		logic [3:0] pin_analog_select;
		logic [adcctl_pkg::DIV_WIDTH-1:0] div_count;
		logic [3:0] bit_index;
		logic [adcctl_pkg::RESULT_WIDTH-1:0] shift;
		logic [15:0] result_pair;
		logic done;
		logic ack;
		logic [31:0] rdata;
	} adcctl_regs_t;

	adcctl_regs_t s_q;
	adcctl_regs_t s_d;

	logic [adcctl_pkg::DIV_WIDTH-1:0] div_limit;
	logic tick;
	logic req;
	logic wr_lane0;
	logic [7:0] ctrl_read;
	logic [7:0] analog_pin_and_clock_select_read;
	logic [adcctl_pkg::RESULT_WIDTH-1:0] final_value;

	// ----------------------------------------------------------------
	// Conversion clock selection.
	// ----------------------------------------------------------------
	always_comb begin
		if (s_q.conversion_clock_select[1:0] == adcctl_pkg::CLK_RC_LOW_BITS) begin
			div_limit = adcctl_pkg::DIV_WIDTH'(adcctl_pkg::RC_CLOCK_CYCLES - 1);
		end else begin
			case (s_q.conversion_clock_select)
				adcctl_pkg::CLK_DIV2: div_limit = adcctl_pkg::DIV_WIDTH'(1);
				adcctl_pkg::CLK_DIV4: div_limit = adcctl_pkg::DIV_WIDTH'(3);
				adcctl_pkg::CLK_DIV8: div_limit = adcctl_pkg::DIV_WIDTH'(7);
				adcctl_pkg::CLK_DIV16: div_limit = adcctl_pkg::DIV_WIDTH'(15);
				adcctl_pkg::CLK_DIV32: div_limit = adcctl_pkg::DIV_WIDTH'(31);
				adcctl_pkg::CLK_DIV64: div_limit = adcctl_pkg::DIV_WIDTH'(63);
				default: div_limit = adcctl_pkg::DIV_WIDTH'(1);
			endcase
		end
	end

	assign tick = (s_q.div_count >= div_limit);

	// ----------------------------------------------------------------
	// Register read views.
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_read = 8'h00;
		ctrl_read[adcctl_pkg::RESULT_JUSTIFY_BIT] = s_q.result_justify;
		ctrl_read[adcctl_pkg::REFERENCE_SOURCE_SELECT_BIT] = s_q.reference_source_select;
		ctrl_read[adcctl_pkg::CHANNEL_SELECT_LSB +: 3] = s_q.input_channel_select;
		ctrl_read[adcctl_pkg::CONVERSION_STATUS_BIT] = s_q.conversion_status;
		ctrl_read[adcctl_pkg::CONVERTER_POWER_ON_BIT] = s_q.converter_power_on;
		analog_pin_and_clock_select_read = 8'h00;
		analog_pin_and_clock_select_read[adcctl_pkg::CLOCK_SELECT_LSB +: 3] = s_q.conversion_clock_select;
		analog_pin_and_clock_select_read[3:0] = s_q.pin_analog_select;
	end

	assign req = WB_CYC_I && WB_STB_I && !s_q.ack;
	assign wr_lane0 = req && WB_WE_I && WB_SEL_I[0];

	// The bits taken so far sit in the low bits of the shift register; the last
	// decision joins them on the way out.
	assign final_value = {s_q.shift[adcctl_pkg::RESULT_WIDTH-2:0], CORE_BIT};

	// ----------------------------------------------------------------
	// Next state.
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.ack = req;
		s_d.done = 1'b0;
		s_d.rdata = 32'h0000_0000;

		if (req && !WB_WE_I) begin
			case (WB_ADR_I)
				adcctl_pkg::CONVERTER_CONTROL_ADDR: s_d.rdata = {24'h00_0000, ctrl_read};
				adcctl_pkg::ANALOG_PIN_AND_CLOCK_SELECT_ADDR: s_d.rdata = {24'h00_0000, analog_pin_and_clock_select_read};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end

		if (wr_lane0 && WB_ADR_I == adcctl_pkg::ANALOG_PIN_AND_CLOCK_SELECT_ADDR) begin
			s_d.conversion_clock_select = WB_DAT_I[adcctl_pkg::CLOCK_SELECT_LSB +: 3];
			s_d.pin_analog_select = WB_DAT_I[3:0];
		end

		if (wr_lane0 && WB_ADR_I == adcctl_pkg::CONVERTER_CONTROL_ADDR) begin
			s_d.result_justify = WB_DAT_I[adcctl_pkg::RESULT_JUSTIFY_BIT];
			s_d.reference_source_select = WB_DAT_I[adcctl_pkg::REFERENCE_SOURCE_SELECT_BIT];
			s_d.input_channel_select = WB_DAT_I[adcctl_pkg::CHANNEL_SELECT_LSB +: 3];
			s_d.converter_power_on = WB_DAT_I[adcctl_pkg::CONVERTER_POWER_ON_BIT];
			// Writing 1 with the enable bit also 1 starts a conversion; writing 0 aborts one in flight.
			s_d.conversion_status = WB_DAT_I[adcctl_pkg::CONVERSION_STATUS_BIT]
				&& WB_DAT_I[adcctl_pkg::CONVERTER_POWER_ON_BIT];
		end

		if (s_q.div_count >= div_limit) begin
			s_d.div_count = '0;
		end else begin
			s_d.div_count = s_q.div_count + adcctl_pkg::DIV_WIDTH'(1);
		end

		case (s_q.state)
			ADCCTL_IDLE: begin
				s_d.bit_index = '0;
				if (s_q.conversion_status && s_q.converter_power_on) begin
					s_d.state = ADCCTL_CONVERT;
					s_d.shift = '0;
					s_d.div_count = '0;
				end
			end
			ADCCTL_CONVERT: begin
				if (!s_d.conversion_status || !s_d.converter_power_on) begin
					s_d.state = ADCCTL_IDLE;
					s_d.conversion_status = 1'b0;
				end else if (tick) begin
					if (s_q.bit_index == 4'(CONV_BITS - 1)) begin
						if (s_q.result_justify) begin
							s_d.result_pair = {6'h00, final_value};
						end else begin
							s_d.result_pair = {final_value, 6'h00};
						end
						s_d.state = ADCCTL_FINISH;
					end else begin
						s_d.shift = {s_q.shift[adcctl_pkg::RESULT_WIDTH-2:0], CORE_BIT};
						s_d.bit_index = s_q.bit_index + 4'h1;
					end
				end
			end
			ADCCTL_FINISH: begin
				// Hardware clear of the status bit wins over a same-cycle write.
				s_d.conversion_status = 1'b0;
				s_d.done = 1'b1;
				s_d.state = ADCCTL_IDLE;
			end
			default: begin
				s_d.state = ADCCTL_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			s_q <= '0;
			s_q.state <= ADCCTL_IDLE;
			s_q.conversion_clock_select <= adcctl_pkg::CLOCK_SELECT_RESET;
			s_q.pin_analog_select <= adcctl_pkg::PIN_ANALOG_SELECT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	assign WB_ACK_O = s_q.ack;
	assign WB_DAT_O = s_q.rdata;
	assign CORE_POWER_ON = s_q.converter_power_on;
	assign CORE_SAMPLE = (s_q.state == ADCCTL_CONVERT) && tick;
	assign CORE_REF_EXTERNAL = s_q.reference_source_select;
	assign CORE_CHANNEL = s_q.input_channel_select[1:0];
	assign CORE_CHANNEL_VALID = !s_q.input_channel_select[2];
	assign PIN_ANALOG = s_q.pin_analog_select;
	assign PIN_DIGITAL_IN_EN = ~s_q.pin_analog_select;
	assign RESULT_PAIR = s_q.result_pair;
	assign CONVERSION_DONE = s_q.done;
endmodule

//--- tb/adcctl_chk.sv
/* Checker for the converter control block.
 Sees only the top ports; bound from tb. */
`timescale 1ns/1ps
module adcctl_chk (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [9:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic CORE_POWER_ON,
	input wire logic CORE_SAMPLE,
	input wire logic [3:0] PIN_ANALOG,
	input wire logic [3:0] PIN_DIGITAL_IN_EN,
	input wire logic CONVERSION_DONE
);
	logic rd;
	assign rd = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held");
	chk_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("no ack");
	chk_high_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
		else $error("upper data set");
	chk_ctrl_gap: assert property (rd && WB_ADR_I == 10'h07C |=> !WB_DAT_O[5])
		else $error("gap bit set");
	chk_sel_top: assert property (rd && WB_ADR_I == 10'h27C |=> !WB_DAT_O[7])
		else $error("select top bit set");
	chk_pin_inv: assert property (PIN_DIGITAL_IN_EN == ~PIN_ANALOG)
		else $error("digital enable wrong");
	chk_sample_on: assert property (CORE_SAMPLE |-> CORE_POWER_ON)
		else $error("sample while off");
	chk_done_pulse: assert property (CONVERSION_DONE |=> !CONVERSION_DONE)
		else $error("done held");
	chk_reset_vals: assert property ($past(RESET) |-> PIN_ANALOG == 4'hF && !CORE_POWER_ON)
		else $error("reset values");
endmodule

//--- tb/adcctl_core_model.sv
/* Analog core model: returns a fixed code MSB first.
 Assumes one sample pulse per bit, ten per conversion. */
`timescale 1ns/1ps
module adcctl_core_model #(
	parameter logic [9:0] PAT = 10'h2B5
) (
	input wire logic clk,
	input wire logic power_on,
	input wire logic sample,
	output logic bit_o
);
	logic [3:0] idx_q = 4'h0;
	logic tog_q = 1'b0;
	always @(posedge clk) begin
		tog_q <= ~tog_q;
		if (sample)
			idx_q <= (idx_q == 4'h9) ? 4'h0 : idx_q + 4'h1;
	end
	// An unpowered comparator gives no stable answer.
	assign bit_o = power_on ? PAT[4'h9 - idx_q] : tog_q;
endmodule

//--- tb/tb.sv
/* Register-level bench for the converter control block.
 Assumes the core model above on the analog side. */
`timescale 1ns/1ps
module tb;
	logic CLK_SYS = 0, RESET = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
	logic [9:0] WB_ADR_I = 0;
	logic [3:0] WB_SEL_I = 4'hF;
	logic [31:0] WB_DAT_I = 0, WB_DAT_O;
	logic WB_ACK_O, CORE_BIT, CORE_POWER_ON, CORE_SAMPLE, CORE_REF_EXTERNAL;
	logic CORE_CHANNEL_VALID, CONVERSION_DONE;
	logic [1:0] CORE_CHANNEL;
	logic [3:0] PIN_ANALOG, PIN_DIGITAL_IN_EN;
	logic [15:0] RESULT_PAIR;
	logic [7:0] rdata;
	int error_cnt = 0, check_count = 0, cyc = 0, n, done_cnt = 0;
	int per[8] = '{2, 8, 32, 40, 4, 16, 64, 40};
	localparam logic [9:0] CTRL = adcctl_pkg::CONVERTER_CONTROL_ADDR;
	localparam logic [9:0] SEL = adcctl_pkg::ANALOG_PIN_AND_CLOCK_SELECT_ADDR;
	localparam logic [9:0] PAT = 10'h2B5;
	adcctl_top dut (.*);
	adcctl_core_model #(.PAT(PAT)) core (.clk(CLK_SYS), .power_on(CORE_POWER_ON),
		.sample(CORE_SAMPLE), .bit_o(CORE_BIT));
	always #25 CLK_SYS = ~CLK_SYS;
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		WB_CYC_I <= 1;
		WB_STB_I <= 1;
		WB_WE_I <= w;
		WB_ADR_I <= a;
		WB_DAT_I <= {24'h0, d};
		@(posedge CLK_SYS);
		while (WB_ACK_O !== 1'b1) @(posedge CLK_SYS);
		rdata = WB_DAT_O[7:0];
		WB_CYC_I <= 0;
		WB_STB_I <= 0;
		@(posedge CLK_SYS);
	endtask
	task rdchk(input string nm, input logic [9:0] a, input logic [7:0] e);
		bus(0, a, 8'h00);
		chk(nm, {8'h0, e}, {8'h0, rdata});
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Counts completion pulses so every finished conversion is seen once.
	always @(posedge CLK_SYS) begin
		if (!RESET && CONVERSION_DONE === 1'b1)
			done_cnt++;
	end
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test;
		end
	end
	initial begin
		repeat (16) @(posedge CLK_SYS);
		RESET <= 0;
		@(posedge CLK_SYS);
		rdchk("ctrl", CTRL, 8'h00);
		rdchk("sel", SEL, 8'h0F);
		rdchk("unmapped", 10'h000, 8'h00);
		$display("test reset done");
		bus(1, CTRL, 8'hFC);
		rdchk("gap", CTRL, 8'hDC);
		chk("chan7", 16'h2, {14'h0, CORE_REF_EXTERNAL, CORE_CHANNEL_VALID});
		for (int ch = 0; ch < 4; ch++) begin
			bus(1, CTRL, {3'h0, ch[2:0], 2'h0});
			chk("chan", {13'h0, ch[1:0], 1'b1}, {13'h0, CORE_CHANNEL, CORE_CHANNEL_VALID});
			chk("ref", 16'h0, {15'h0, CORE_REF_EXTERNAL});
		end
		bus(1, SEL, 8'hF5);
		rdchk("seltop", SEL, 8'h75);
		WB_SEL_I <= 4'hE;
		bus(1, SEL, 8'h00);
		WB_SEL_I <= 4'hF;
		rdchk("nolane", SEL, 8'h75);
		chk("pins", 16'hA5, {8'h0, PIN_DIGITAL_IN_EN, PIN_ANALOG});
		bus(1, CTRL, 8'h02);
		rdchk("nostart", CTRL, 8'h00);
		$display("test fields done");
		for (int c = 0; c < 8; c++) begin
			bus(1, SEL, {1'b0, c[2:0], 4'hF});
			bus(1, CTRL, {c[0], 7'h01});
			bus(1, CTRL, {c[0], 7'h03});
			while (CORE_SAMPLE !== 1'b1) @(posedge CLK_SYS);
			n = 0;
			do begin
				@(posedge CLK_SYS);
				n++;
			end while (CORE_SAMPLE !== 1'b1);
			chk("period", 16'(per[c]), 16'(n));
			do bus(0, CTRL, 8'h00); while (rdata[1] !== 1'b0);
			chk("idle", {8'h0, c[0], 7'h01}, {8'h0, rdata});
			chk("result", c[0] ? {6'h0, PAT} : {PAT, 6'h0}, RESULT_PAIR);
			repeat (2 * per[c]) @(posedge CLK_SYS);
		end
		chk("donecnt", 16'h8, 16'(done_cnt));
		bus(1, CTRL, 8'h03);
		bus(1, CTRL, 8'h01);
		rdchk("abort", CTRL, 8'h01);
		repeat (100) @(posedge CLK_SYS);
		chk("abortres", {6'h0, PAT}, RESULT_PAIR);
		chk("abortdone", 16'h8, 16'(done_cnt));
		$display("test conversions done");
		finish_test;
	end
endmodule
bind adcctl_top adcctl_chk chk_i (.*);
